// [rtl/pbm_pkg.sv]
// Purpose: shared constants for the time-protocol message classifier and best-master logic
// Assumes: message type codes follow the published version 2 wire encoding
// Notes:   own advertised properties are fixed values; the identifier comes from the station address
package pbm_pkg;

  // message type codes (low nibble of the first header byte)
  localparam logic [3:0] MSG_SYNC       = 4'h0;
  localparam logic [3:0] MSG_DELAY_REQ  = 4'h1;
  localparam logic [3:0] MSG_PDLY_REQ   = 4'h2;
  localparam logic [3:0] MSG_PDLY_RESP  = 4'h3;
  localparam logic [3:0] MSG_FOLLOW_UP  = 4'h8;
  localparam logic [3:0] MSG_DELAY_RESP = 4'h9;
  localparam logic [3:0] MSG_PDLY_RFUP  = 4'hA;
  localparam logic [3:0] MSG_ANNOUNCE   = 4'hB;
  localparam logic [3:0] MSG_SIGNALING  = 4'hC;
  localparam logic [3:0] MSG_MANAGEMENT = 4'hD;

  // widths of the compared properties, correction and timestamps
  localparam int PRIO_W  = 8;
  localparam int CLASS_W = 8;
  localparam int ACC_W   = 8;
  localparam int VAR_W   = 16;
  localparam int ID_W    = 64;
  localparam int CORR_W  = 64;
  localparam int TS_W    = 80;

  // properties this recorder advertises
  localparam logic [PRIO_W-1:0]  OWN_PRIO1 = 8'h80;    // 128
  localparam logic [CLASS_W-1:0] OWN_CLASS = 8'hF8;    // 248
  localparam logic [ACC_W-1:0]   OWN_ACC   = 8'hFE;
  localparam logic [VAR_W-1:0]   OWN_VAR   = 16'hFFFF;
  localparam logic [PRIO_W-1:0]  OWN_PRIO2 = 8'h7A;    // 122

  // identifier built from a 48-bit station address
  localparam int               MAC_W      = 48;
  localparam logic [15:0]      ID_FILLER  = 16'hFFFE;
  localparam int               ID_HI_W    = 24;

  // event class test, used on both paths
  function automatic logic pbm_is_event(input logic [3:0] code);
    return (code == MSG_SYNC) || (code == MSG_DELAY_REQ) ||
           (code == MSG_PDLY_REQ) || (code == MSG_PDLY_RESP);
  endfunction : pbm_is_event

  // general class test
  function automatic logic pbm_is_general(input logic [3:0] code);
    return (code == MSG_ANNOUNCE) || (code == MSG_FOLLOW_UP) ||
           (code == MSG_DELAY_RESP) || (code == MSG_PDLY_RFUP) ||
           (code == MSG_MANAGEMENT) || (code == MSG_SIGNALING);
  endfunction : pbm_is_general

endpackage : pbm_pkg

// [rtl/pbm_compare.sv]
// Purpose: best-master comparison of a candidate against a reference
// Assumes: all properties present at the same time, combinational use
// Notes:   smaller wins; first differing property decides
`timescale 1ns/1ps
`default_nettype none
module pbm_compare (
  // candidate properties
  input  wire logic [pbm_pkg::PRIO_W-1:0]  cand_prio1,
  input  wire logic [pbm_pkg::CLASS_W-1:0] cand_class,
  input  wire logic [pbm_pkg::ACC_W-1:0]   cand_acc,
  input  wire logic [pbm_pkg::VAR_W-1:0]   cand_var,
  input  wire logic [pbm_pkg::PRIO_W-1:0]  cand_prio2,
  input  wire logic [pbm_pkg::ID_W-1:0]    cand_id,
  // reference properties
  input  wire logic [pbm_pkg::PRIO_W-1:0]  ref_prio1,
  input  wire logic [pbm_pkg::CLASS_W-1:0] ref_class,
  input  wire logic [pbm_pkg::ACC_W-1:0]   ref_acc,
  input  wire logic [pbm_pkg::VAR_W-1:0]   ref_var,
  input  wire logic [pbm_pkg::PRIO_W-1:0]  ref_prio2,
  input  wire logic [pbm_pkg::ID_W-1:0]    ref_id,
  // verdict
  output logic                             better,
  output logic                             equal
);

  // one wide key, fields concatenated most significant first, so that a
  // single magnitude compare gives the strict lexical order
  // key width: two priorities, class, accuracy, variance and identifier
  localparam int KEY_W = 2 * pbm_pkg::PRIO_W + pbm_pkg::CLASS_W + pbm_pkg::ACC_W +
                         pbm_pkg::VAR_W + pbm_pkg::ID_W;
  logic [KEY_W-1:0] cand_key;  // packed candidate
  logic [KEY_W-1:0] ref_key;   // packed reference

  assign cand_key = {cand_prio1, cand_class, cand_acc, cand_var, cand_prio2, cand_id};
  assign ref_key  = {ref_prio1, ref_class, ref_acc, ref_var, ref_prio2, ref_id};

  assign better = (cand_key < ref_key);
  assign equal  = (cand_key == ref_key);

endmodule : pbm_compare
`default_nettype wire

// [rtl/pbm_top.sv]
// Purpose: message classification, timestamp capture and best-master selection
// Assumes: rx/tx message strobes come from framing logic on the same clock
// Notes:   only end-to-end two-step operation; no peer-delay service
`timescale 1ns/1ps
`default_nettype none
module pbm_top (
  // clock, reset and enable
  input  wire logic                             clock,
  input  wire logic                             rst,
  input  wire logic                             enable,
  // station address
  input  wire logic [pbm_pkg::MAC_W-1:0]        mac_addr,
  // receive path
  input  wire logic                             rx_valid,
  input  wire logic [3:0]                       rx_type,
  input  wire logic [pbm_pkg::TS_W-1:0]         rx_time,
  input  wire logic [pbm_pkg::TS_W-1:0]         rx_origin,
  input  wire logic [pbm_pkg::CORR_W-1:0]       rx_corr,
  // announce payload
  input  wire logic [pbm_pkg::PRIO_W-1:0]       ann_prio1,
  input  wire logic [pbm_pkg::CLASS_W-1:0]      ann_class,
  input  wire logic [pbm_pkg::ACC_W-1:0]        ann_acc,
  input  wire logic [pbm_pkg::VAR_W-1:0]        ann_var,
  input  wire logic [pbm_pkg::PRIO_W-1:0]       ann_prio2,
  input  wire logic [pbm_pkg::ID_W-1:0]         ann_id,
  // transmit path
  input  wire logic                             tx_valid,
  input  wire logic [3:0]                       tx_type,
  input  wire logic [pbm_pkg::TS_W-1:0]         tx_time,
  // classifier outputs
  output logic                                  rx_event,
  output logic                                  rx_general,
  output logic                                  tx_event,
  output logic                                  ts_capture,
  output logic                                  pdelay_ignored,
  // captured timestamps, corrections and set-complete flag
  output logic [pbm_pkg::TS_W-1:0]              t1_master_tx,
  output logic [pbm_pkg::TS_W-1:0]              t2_local_rx,
  output logic [pbm_pkg::TS_W-1:0]              t3_local_tx,
  output logic [pbm_pkg::TS_W-1:0]              t4_master_rx,
  output logic [pbm_pkg::CORR_W-1:0]            sync_corr,
  output logic [pbm_pkg::CORR_W-1:0]            dreq_corr,
  output logic                                  set_complete,
  // best-master state
  output logic                                  is_master,
  output logic [pbm_pkg::ID_W-1:0]              best_id,
  output logic                                  ann_better,
  output logic                                  ann_equal,
  output logic [pbm_pkg::ID_W-1:0]              own_id
);

  // combinational classification of the current strobes
  logic rx_ev_now;   // receive event now
  logic rx_gen_now;  // receive general now
  logic tx_ev_now;   // transmit event now
  logic ann_now;     // announce received now

  assign rx_ev_now  = rx_valid && pbm_pkg::pbm_is_event(rx_type);
  assign tx_ev_now  = tx_valid && pbm_pkg::pbm_is_event(tx_type);
  assign rx_gen_now = rx_valid && pbm_pkg::pbm_is_general(rx_type);
  assign ann_now    = rx_valid && (rx_type == pbm_pkg::MSG_ANNOUNCE);

  // best recorded master, initially ourselves
  logic [pbm_pkg::PRIO_W-1:0]  best_prio1;
  logic [pbm_pkg::CLASS_W-1:0] best_class;
  logic [pbm_pkg::ACC_W-1:0]   best_acc;
  logic [pbm_pkg::VAR_W-1:0]   best_var;
  logic [pbm_pkg::PRIO_W-1:0]  best_prio2;
  logic                        cmp_better;  // announce beats best
  logic                        cmp_equal;   // announce same as best
  logic [pbm_pkg::ID_W-1:0]    next_own_id; // identifier from address

  assign next_own_id = {mac_addr[pbm_pkg::MAC_W-1 -: pbm_pkg::ID_HI_W], pbm_pkg::ID_FILLER,
                        mac_addr[pbm_pkg::ID_HI_W-1:0]};

  // comparison of the incoming announce against current best
  pbm_compare u_cmp (
    .cand_prio1 (ann_prio1),
    .cand_class (ann_class),
    .cand_acc   (ann_acc),
    .cand_var   (ann_var),
    .cand_prio2 (ann_prio2),
    .cand_id    (ann_id),
    .ref_prio1  (best_prio1),
    .ref_class  (best_class),
    .ref_acc    (best_acc),
    .ref_var    (best_var),
    .ref_prio2  (best_prio2),
    .ref_id     (best_id),
    .better     (cmp_better),
    .equal      (cmp_equal)
  );

  // classifier strobes, registered so outputs come from flops
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rx_event       <= 1'b0;
      rx_general     <= 1'b0;
      tx_event       <= 1'b0;
      ts_capture     <= 1'b0;
      pdelay_ignored <= 1'b0;
    end
    else if (enable)
    begin
      rx_event   <= rx_ev_now;
      rx_general <= rx_gen_now;
      tx_event   <= tx_ev_now;
      ts_capture <= rx_ev_now || tx_ev_now;
      pdelay_ignored <= rx_valid && ((rx_type == pbm_pkg::MSG_PDLY_REQ) ||
                        (rx_type == pbm_pkg::MSG_PDLY_RESP) ||
                        (rx_type == pbm_pkg::MSG_PDLY_RFUP));
    end
  end

  // two-step slave timestamp set; t1 and t4 arrive in general payloads
  logic [3:0] have;  // t1..t4 gathered flags
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      t1_master_tx <= '0;
      t2_local_rx  <= '0;
      t3_local_tx  <= '0;
      t4_master_rx <= '0;
      sync_corr    <= '0;
      dreq_corr    <= '0;
      have         <= 4'h0;
      set_complete <= 1'b0;
    end
    else if (enable)
    begin
      set_complete <= 1'b0;
      if (rx_valid && rx_type == pbm_pkg::MSG_SYNC)
      begin
        // sync receive time, new set begins
        t2_local_rx <= rx_time;
        sync_corr   <= rx_corr;
        have        <= 4'h2;
      end
      else if (rx_valid && rx_type == pbm_pkg::MSG_FOLLOW_UP)
      begin
        t1_master_tx <= rx_origin;
        sync_corr    <= sync_corr + rx_corr;
        have[0]      <= 1'b1;
      end
      else if (rx_valid && rx_type == pbm_pkg::MSG_DELAY_RESP)
      begin
        t4_master_rx <= rx_origin;
        dreq_corr    <= rx_corr;
        have[3]      <= 1'b1;
        set_complete <= (have[2:0] == 3'h7);
      end
      if (tx_valid && tx_type == pbm_pkg::MSG_DELAY_REQ)
      begin
        t3_local_tx <= tx_time;
        have[2]     <= 1'b1;
      end
    end
  end

  // best-master tracking; announce replaces the best if it is better
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      best_prio1 <= pbm_pkg::OWN_PRIO1;
      best_class <= pbm_pkg::OWN_CLASS;
      best_acc   <= pbm_pkg::OWN_ACC;
      best_var   <= pbm_pkg::OWN_VAR;
      best_prio2 <= pbm_pkg::OWN_PRIO2;
      best_id    <= '0;
      own_id     <= '0;
      is_master  <= 1'b0;
      ann_better <= 1'b0;
      ann_equal  <= 1'b0;
    end
    else if (enable)
    begin
      own_id <= next_own_id;
      // self entry follows the address until a foreign master is held
      if (is_master || best_id == own_id)
      begin
        if (!ann_now || !cmp_better)
          best_id <= next_own_id;
      end
      ann_better <= ann_now && cmp_better;
      ann_equal  <= ann_now && cmp_equal;
      if (ann_now && cmp_better)
      begin
        best_prio1 <= ann_prio1;
        best_class <= ann_class;
        best_acc   <= ann_acc;
        best_var   <= ann_var;
        best_prio2 <= ann_prio2;
        best_id    <= ann_id;
        is_master  <= 1'b0;
      end
      else
        is_master  <= (best_id == own_id);
    end
  end

  // a_capture_event: strobe follows an event one cycle later
  a_capture_event: assert property (@(posedge clock) disable iff (rst)
    (enable && (rx_ev_now || tx_ev_now)) |=> ts_capture)
    else $error("capture strobe missing after event");

  // a_no_general_cap: general alone never captures
  a_no_general_cap: assert property (@(posedge clock) disable iff (rst)
    (enable && rx_gen_now && !tx_ev_now) |=> !ts_capture)
    else $error("capture strobe on general message");

  // a_better_adopt: better announce adopted as best
  a_better_adopt: assert property (@(posedge clock) disable iff (rst)
    (enable && ann_now && cmp_better) |=> (best_id == $past(ann_id) && ann_better))
    else $error("better announce not adopted");

  // a_first_decides: lower priority1 always better
  a_first_decides: assert property (@(posedge clock) disable iff (rst)
    (ann_prio1 < best_prio1) |-> cmp_better)
    else $error("earlier property did not decide");

  // a_smaller_wins: larger priority1 never better
  a_smaller_wins: assert property (@(posedge clock) disable iff (rst)
    (ann_prio1 > best_prio1) |-> !cmp_better)
    else $error("larger value judged better");

  // a_equal_flag: equal excludes better
  a_equal_flag: assert property (@(posedge clock) disable iff (rst)
    cmp_equal |-> (!cmp_better && ann_id == best_id && ann_var == best_var))
    else $error("equal flag inconsistent");

  // a_sync_time: sync receive time stored
  a_sync_time: assert property (@(posedge clock) disable iff (rst)
    (enable && rx_valid && rx_type == pbm_pkg::MSG_SYNC) |=> (t2_local_rx == $past(rx_time)))
    else $error("sync receive time not stored");

  // a_pdelay_flag: peer-delay request flagged
  a_pdelay_flag: assert property (@(posedge clock) disable iff (rst)
    (enable && rx_valid && rx_type == pbm_pkg::MSG_PDLY_REQ) |=> pdelay_ignored)
    else $error("peer delay not flagged");

endmodule : pbm_top
`default_nettype wire

// [tb/pbm_far_clock.sv]
// Purpose: far-side clock model that sends received protocol messages
// Assumes: one message per send call, bench clock
// Notes:   payload lines are scrambled between messages, never left stale
`timescale 1ns/1ps
`default_nettype none
module pbm_far_clock #(
  parameter logic [63:0] RES_DELAY = 64'h0000_0000_0000_0010  // switch residence
) (
  // bench clock
  input  wire logic         clock,
  // message towards the recorder
  output logic              rx_valid,
  output logic [3:0]        rx_type,
  output logic [79:0]       rx_time,
  output logic [79:0]       rx_origin,
  output logic [63:0]       rx_corr,
  output logic [111:0]      ann
);
  // quiet line at time zero
  initial
  begin
    rx_valid = 1'b0;
    rx_type = 4'h4;
    rx_time = 80'h0;
    rx_origin = 80'h0;
    rx_corr = 64'h0;
    ann = 112'h0;
  end

  // one-cycle message; fields flip afterwards so stale data cannot pass
  task automatic send(input logic [3:0] t, input logic [79:0] tm, org,
                      input logic [63:0] c, input logic [111:0] a);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_type <= t;
    rx_time <= tm;
    // origin stamp carried by follow-up and delay response
    rx_origin <= org;
    // switch residence delay folded into the correction
    rx_corr <= c + RES_DELAY;
    // announce properties as an upstream boundary clock presents them
    ann <= a;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_type <= ~t;
    rx_time <= ~tm;
    rx_origin <= ~org;
    rx_corr <= ~rx_corr;
    ann <= ~a;
  endtask : send
endmodule : pbm_far_clock
`default_nettype wire

// [tb/pbm_top_tb.sv]
// Purpose: self-checking bench for classifier, stamps and best-master
// Assumes: result pulses come one cycle after each message
// Notes:   driver queues notes, a monitor pops one per result cycle
`timescale 1ns/1ps
`default_nettype none
module pbm_top_tb;
  typedef struct packed {
    logic [8:0]  fl;    // pdelay, rx ev, gen, tx ev, cap, better, equal, done, master
    logic [63:0] best;  // expected best id
    logic [2:0]  sel;   // stamp to compare, zero for none
    logic [79:0] ts;    // expected stamp
    logic [63:0] corr;  // expected sync or delay correction
  } pbm_note_type;
  localparam logic [63:0] RES = 64'h0000_0000_0000_0123;  // residence delay
  int pos[6] = '{104, 96, 88, 72, 64, 0};  // field low bits, priority order
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic enable = 1'b1;
  logic [47:0] mac_addr = 48'h0;
  logic tx_valid = 1'b0;
  logic [3:0] tx_type = 4'h0;
  logic [79:0] tx_time = 80'h0;
  logic rx_valid, rx_event, rx_general, tx_event, ts_capture, set_complete;
  logic is_master, ann_better, ann_equal, sent_d, pdelay_ignored;
  logic [3:0] rx_type;
  logic [79:0] rx_time, rx_origin, t1_master_tx, t2_local_rx, t3_local_tx, t4_master_rx;
  logic [63:0] rx_corr, sync_corr, dreq_corr, best_id, own_id;
  logic [111:0] ann;
  logic [111:0] held;  // model of best properties
  logic master = 1'b1;
  logic hs = 1'b0;  // set progress: sync, follow-up, delay request
  logic hf = 1'b0;
  logic hd = 1'b0;
  logic [63:0] scorr = 64'h0;  // model of accumulated sync correction
  logic [8:0] prev_fl = 9'h0;  // flags last shown, held while frozen
  logic [15:0] seed = 16'h004B;
  pbm_note_type notes[$];
  int fails = 0;
  int total_checks = 0;

  always #50 clock = ~clock;

  pbm_far_clock #(.RES_DELAY(RES)) u_far (.clock(clock), .rx_valid(rx_valid),
    .rx_type(rx_type), .rx_time(rx_time), .rx_origin(rx_origin), .rx_corr(rx_corr),
    .ann(ann));

  pbm_top u_dut (.clock(clock), .rst(rst), .enable(enable), .mac_addr(mac_addr),
    .rx_valid(rx_valid), .rx_type(rx_type), .rx_time(rx_time), .rx_origin(rx_origin),
    .rx_corr(rx_corr), .ann_prio1(ann[111:104]), .ann_class(ann[103:96]),
    .ann_acc(ann[95:88]), .ann_var(ann[87:72]), .ann_prio2(ann[71:64]),
    .ann_id(ann[63:0]), .tx_valid(tx_valid), .tx_type(tx_type), .tx_time(tx_time),
    .rx_event(rx_event), .rx_general(rx_general), .tx_event(tx_event),
    .ts_capture(ts_capture), .pdelay_ignored(pdelay_ignored), .t1_master_tx(t1_master_tx),
    .t2_local_rx(t2_local_rx), .t3_local_tx(t3_local_tx), .t4_master_rx(t4_master_rx),
    .sync_corr(sync_corr), .dreq_corr(dreq_corr), .set_complete(set_complete),
    .is_master(is_master), .best_id(best_id), .ann_better(ann_better),
    .ann_equal(ann_equal), .own_id(own_id));

  // lfsr source for all random stimulus
  function automatic logic [15:0] rand16();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rand16

  function automatic logic [79:0] pick(input logic [2:0] s);
    return s == 3'd1 ? t1_master_tx : s == 3'd2 ? t2_local_rx :
           s == 3'd3 ? t3_local_tx : t4_master_rx;
  endfunction : pick

  task automatic check(input logic [79:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  // model one message, queue its note, then drive it
  task automatic msg(input logic tx, input logic [3:0] t, input logic [111:0] a);
    pbm_note_type n;
    logic [79:0] tm;
    logic [79:0] org;
    logic [63:0] c;
    logic ev, gen, bet, eq, done, pd;
    tm = {rand16(), rand16(), rand16(), rand16(), rand16()};
    org = {rand16(), rand16(), rand16(), rand16(), rand16()};
    c = {rand16(), rand16(), rand16(), rand16()};
    ev = enable && t < 4'h4;
    gen = enable && !tx && t >= 4'h8 && t <= 4'hD;
    bet = enable && !tx && t == 4'hB && a < held;
    eq = enable && !tx && t == 4'hB && a == held;
    pd = enable && !tx && (t == 4'h2 || t == 4'h3 || t == 4'hA);
    n.sel = !enable ? 3'd0 : tx ? (t == 4'h1 ? 3'd3 : 3'd0) :
            t == 4'h0 ? 3'd2 : t == 4'h8 ? 3'd1 : t == 4'h9 ? 3'd4 : 3'd0;
    n.ts = (n.sel == 3'd1 || n.sel == 3'd4) ? org : tm;
    // follow-up correction adds onto the sync one; delay response stands alone
    if (n.sel == 3'd1)
      scorr = scorr + c + RES;
    else if (n.sel == 3'd2)
      scorr = c + RES;
    n.corr = n.sel == 3'd4 ? c + RES : scorr;
    done = n.sel == 3'd4 && hd;
    hd = n.sel == 3'd3 ? hf : (n.sel == 3'd2 ? 1'b0 : hd);
    hf = n.sel == 3'd1 ? hs : (n.sel == 3'd2 ? 1'b0 : hf);
    hs = n.sel == 3'd2 ? 1'b1 : hs;
    if (bet)
    begin
      held = a;
      master = 1'b0;
    end
    n.fl = {pd, ev && !tx, gen, ev && tx, ev, bet, eq, done, master};
    // a frozen block keeps showing its previous pulses
    if (!enable)
      n.fl = prev_fl;
    prev_fl = n.fl;
    n.best = held[63:0];
    notes.push_back(n);
    if (tx)
    begin
      @(posedge clock);
      tx_valid <= 1'b1;
      tx_type <= t;
      tx_time <= tm;
      @(posedge clock);
      tx_valid <= 1'b0;
    end
    else
      u_far.send(t, tm, org, c, a);
  endtask : msg

  // result cycle follows every strobe by one edge
  always @(posedge clock)
    sent_d <= rx_valid | tx_valid;

  // monitor: one note per result cycle
  always @(negedge clock)
  begin
    pbm_note_type n;
    if (sent_d === 1'b1)
    begin
      n = notes.pop_front();
      check(80'({rx_event, rx_general, tx_event, ts_capture}), 80'(n.fl[7:4]), "class");
      check(80'({ann_better, ann_equal}), 80'(n.fl[3:2]), "verdict");
      check(80'(set_complete), 80'(n.fl[1]), "set");
      check(80'(is_master), 80'(n.fl[0]), "master");
      check(80'(best_id), 80'(n.best), "best");
      if (n.sel != 3'd0)
        check(pick(n.sel), n.ts, "stamp");
      check(80'(pdelay_ignored), 80'(n.fl[8]), "pdelay");
      if (n.sel == 3'd1 || n.sel == 3'd2)
        check(80'(sync_corr), 80'(n.corr), "corr");
      if (n.sel == 3'd4)
        check(80'(dreq_corr), 80'(n.corr), "dcorr");
    end
  end

  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    stop_test();
  end

  initial
  begin
    logic [111:0] dl, keep, cand, rnd;
    logic [15:0] r;
    mac_addr <= {rand16(), rand16(), rand16()};
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    held = {8'h80, 8'hF8, 8'hFE, 16'hFFFF, 8'h7A, mac_addr[47:24], 16'hFFFE, mac_addr[23:0]};
    check(80'(own_id), 80'(held[63:0]), "own id");
    check(80'({is_master, best_id}), 80'({1'b1, held[63:0]}), "own best");
    $display("test reset done");
    for (int i = 0; i < 16; i++)
      msg(1'b0, 4'(i), held);
    msg(1'b1, 4'h1, held);
    msg(1'b1, 4'h8, held);
    $display("test codes done");
    msg(1'b0, 4'h0, held);
    msg(1'b0, 4'h8, held);
    msg(1'b1, 4'h1, held);
    msg(1'b0, 4'h9, held);
    $display("test exchange done");
    // companion unit with priority two of 128 must lose
    msg(1'b0, 4'hB, {held[111:72], 8'h80, 64'h0});
    enable <= 1'b0;
    @(posedge clock);
    msg(1'b0, 4'h0, held);
    msg(1'b0, 4'hB, 112'h0);
    enable <= 1'b1;
    @(posedge clock);
    $display("test freeze done");
    for (int i = 0; i < 40; i++)
    begin
      r = rand16();
      dl = 112'h1 << pos[r[2:0] % 6];
      keep = ~112'h0 << pos[r[2:0] % 6];
      rnd = {rand16(), rand16(), rand16(), rand16(), rand16(), rand16(), rand16()};
      cand = ((((held & keep) + (r[3] ? dl : -dl)) & keep) | (rnd & ~keep));
      msg(1'b0, 4'hB, r[4] ? held : cand);
    end
    $display("test selection done");
    for (int i = 0; i < 10 && notes.size() > 0; i++)
      @(posedge clock);
    if (notes.size() > 0)
      fails++;
    stop_test();
  end
endmodule : pbm_top_tb
`default_nettype wire
